// ===== hw/uart_status_pkg.sv
// constants and types for the uart line and modem status block
package uart_status_pkg;
   // ----------------------------------------
   // register bus
   // ----------------------------------------
   localparam int ADDR_W = 3;
   localparam logic [2:0] OFS_RX_DATA = 3'h0;
   localparam logic [2:0] OFS_LINE_STATUS = 3'h1;
   localparam logic [2:0] OFS_MODEM_STATUS = 3'h2;
   localparam logic [2:0] OFS_MODEM_CONTROL = 3'h3;
   localparam logic [2:0] OFS_FIFO_CONTROL = 3'h4;
   localparam logic [2:0] OFS_IRQ_STATUS = 3'h5;
   localparam logic [2:0] OFS_IRQ_MASK = 3'h6;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int LS_DATA_READY = 0;
   localparam int LS_OVERRUN = 1;
   localparam int LS_PARITY = 2;
   localparam int LS_FRAMING = 3;
   localparam int LS_HOLD_EMPTY = 5;
   localparam int LS_ALL_EMPTY = 6;
   localparam int MC_DTR = 0;
   localparam int MC_RTS = 1;
   localparam int MC_OUT_ONE = 2;
   localparam int MC_OUT_TWO = 3;
   localparam int MC_LOOPBACK = 4;
   localparam int FC_ENABLE = 0;
   localparam int FC_FLUSH = 1;
   // modem bit order inside the 4-bit groups: cts, dsr, ri, cd
   localparam int MS_CTS = 0;
   localparam int MS_DSR = 1;
   localparam int MS_RI = 2;
   localparam int MS_CD = 3;
   localparam int IRQ_W = 5;
   localparam int IS_OVERRUN = 0;
   localparam int IS_PARITY = 1;
   localparam int IS_FRAMING = 2;
   localparam int IS_MODEM = 3;
   localparam int IS_DATA = 4;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [4:0] MODEM_CONTROL_RST = 5'h00;
   localparam logic [4:0] IRQ_MASK_RST = 5'h00;
   localparam logic [1:0] TX_EMPTY_RST = 2'h3;
   // ----------------------------------------
   // receive queue
   // ----------------------------------------
   localparam int QUEUE_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [4:0] QUEUE_FULL_CNT = 5'h10;
   localparam logic [4:0] HOLD_FULL_CNT = 5'h01;

   typedef struct packed {
      logic framing;
      logic parity;
      logic [7:0] data;
   } rx_word_t;
endpackage : uart_status_pkg

// ===== hw/rx_queue_if.sv
// link between the status block and its receive queue
`timescale 1ns/1ps
interface rx_queue_if;
   logic push;
   uart_status_pkg::rx_word_t push_word;
   logic pop;
   logic flush;
   logic fifo_mode;
   uart_status_pkg::rx_word_t head;
   logic full;
   logic empty;

   modport owner (
      output push, push_word, pop, flush, fifo_mode,
      input head, full, empty
   );
   modport queue (
      input push, push_word, pop, flush, fifo_mode,
      output head, full, empty
   );
endinterface : rx_queue_if

// ===== hw/rx_queue.sv
// receive queue: 16 entries in fifo mode, one holding entry otherwise
`timescale 1ns/1ps
module rx_queue (
   input wire logic mclk_i,
   input wire logic rstn_i,
   rx_queue_if.queue q
);
   typedef struct packed {
      logic [uart_status_pkg::QUEUE_DEPTH-1:0][9:0] mem;
      logic [uart_status_pkg::PTR_W-1:0] wr_ptr;
      logic [uart_status_pkg::PTR_W-1:0] rd_ptr;
      logic [uart_status_pkg::CNT_W-1:0] count;
   } queue_state_t;

   queue_state_t cur;
   queue_state_t next_cur;
   logic do_push;
   logic do_pop;

   // ----------------------------------------
   // flags and head
   // ----------------------------------------
   assign q.full = q.fifo_mode ? (cur.count == uart_status_pkg::QUEUE_FULL_CNT)
                               : (cur.count == uart_status_pkg::HOLD_FULL_CNT);
   assign q.empty = (cur.count == '0);
   assign q.head = uart_status_pkg::rx_word_t'(cur.mem[cur.rd_ptr]);
   assign do_pop = q.pop && !q.empty;
   assign do_push = q.push && (!q.full || do_pop);

   always_comb begin
      next_cur = cur;
      if (do_push) begin
         next_cur.mem[cur.wr_ptr] = q.push_word;
         next_cur.wr_ptr = cur.wr_ptr + 1'b1;
      end
      if (do_pop) begin
         next_cur.rd_ptr = cur.rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
         next_cur.count = cur.count + 1'b1;
      end else if (do_pop && !do_push) begin
         next_cur.count = cur.count - 1'b1;
      end
      if (q.flush) begin
         next_cur.wr_ptr = '0;
         next_cur.rd_ptr = '0;
         next_cur.count = '0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end
endmodule : rx_queue

// ===== hw/uart_line_modem_status.sv
// line status, modem status and interrupt logic of one uart channel
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module uart_line_modem_status (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   output logic modem_irq_o,
   input wire logic rx_char_valid_i,
   input wire logic [7:0] rx_char_i,
   input wire logic rx_parity_bad_i,
   input wire logic rx_stop_bad_i,
   input wire logic tx_hold_empty_i,
   input wire logic tx_all_empty_i,
   input wire logic cd_n_i,
   input wire logic ri_n_i,
   input wire logic dsr_n_i,
   input wire logic cts_n_i,
   output logic dtr_n_o,
   output logic rts_n_o,
   output logic general_output_one_n_o,
   output logic general_output_two_n_o,
   output logic loopback_o
);
   typedef struct packed {
      logic [7:0] rdata;
      logic [4:0] modem_control;
      logic fifo_en;
      logic [4:0] irq_status;
      logic [4:0] irq_mask;
      logic [3:0] delta;
      logic [3:0] prev;
      logic primed;
      logic overrun;
      logic parity_hold;
      logic framing_hold;
      uart_status_pkg::rx_word_t shift;
      logic shift_new;
      logic [1:0] tx_empty;
   } state_t;

   state_t cur;
   state_t next_cur;
   rx_queue_if rxq ();

   logic [3:0] modem_now;
   logic [3:0] delta_set;
   logic [7:0] line_status;
   logic [7:0] modem_status;
   logic loopback;
   logic accept;
   logic overrun_set;
   logic [4:0] irq_set;
   logic rd_rx;
   logic rd_line;
   logic rd_modem;

   rx_queue u_rx_queue (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .q(rxq.queue)
   );

   // ----------------------------------------
   // modem inputs and loopback
   // ----------------------------------------
   assign loopback = cur.modem_control[uart_status_pkg::MC_LOOPBACK];

   always_comb begin
      if (loopback) begin
         modem_now[uart_status_pkg::MS_CD] =
            cur.modem_control[uart_status_pkg::MC_OUT_TWO];
         modem_now[uart_status_pkg::MS_RI] =
            cur.modem_control[uart_status_pkg::MC_OUT_ONE];
         modem_now[uart_status_pkg::MS_DSR] =
            cur.modem_control[uart_status_pkg::MC_DTR];
         modem_now[uart_status_pkg::MS_CTS] =
            cur.modem_control[uart_status_pkg::MC_RTS];
      end else begin
         modem_now[uart_status_pkg::MS_CD] = ~cd_n_i;
         modem_now[uart_status_pkg::MS_RI] = ~ri_n_i;
         modem_now[uart_status_pkg::MS_DSR] = ~dsr_n_i;
         modem_now[uart_status_pkg::MS_CTS] = ~cts_n_i;
      end
   end

   // either edge on cd, dsr, cts
   assign delta_set[uart_status_pkg::MS_CD] = cur.primed &&
      (modem_now[uart_status_pkg::MS_CD] != cur.prev[uart_status_pkg::MS_CD]);
   assign delta_set[uart_status_pkg::MS_DSR] = cur.primed &&
      (modem_now[uart_status_pkg::MS_DSR] != cur.prev[uart_status_pkg::MS_DSR]);
   assign delta_set[uart_status_pkg::MS_CTS] = cur.primed &&
      (modem_now[uart_status_pkg::MS_CTS] != cur.prev[uart_status_pkg::MS_CTS]);
   // ring pin rising means the status bit falls
   assign delta_set[uart_status_pkg::MS_RI] = cur.primed &&
      cur.prev[uart_status_pkg::MS_RI] && !modem_now[uart_status_pkg::MS_RI];

   // upper bits live, change bits from flops
   assign modem_status = {modem_now, cur.delta};
   assign modem_irq_o = |cur.delta;

   // modem outputs are active low and parked inactive in loopback
   assign dtr_n_o = ~(cur.modem_control[uart_status_pkg::MC_DTR] && !loopback);
   assign rts_n_o = ~(cur.modem_control[uart_status_pkg::MC_RTS] && !loopback);
   assign general_output_one_n_o =
      ~(cur.modem_control[uart_status_pkg::MC_OUT_ONE] && !loopback);
   assign general_output_two_n_o =
      ~(cur.modem_control[uart_status_pkg::MC_OUT_TWO] && !loopback);
   assign loopback_o = loopback;

   // ----------------------------------------
   // receive path
   // ----------------------------------------
   assign rd_rx = rd_i && (addr_i == uart_status_pkg::OFS_RX_DATA);
   assign rd_line = rd_i && (addr_i == uart_status_pkg::OFS_LINE_STATUS);
   assign rd_modem = rd_i && (addr_i == uart_status_pkg::OFS_MODEM_STATUS);

   // a full queue with no rx data read in the same cycle leaves the character in the shift register only
   assign accept = cur.shift_new && (!rxq.full || (rd_rx && !rxq.empty));
   // character done while the queue is full and rx data is not read in that cycle
   assign overrun_set = cur.shift_new && !accept;

   assign rxq.push = accept;
   assign rxq.push_word = cur.shift;
   assign rxq.pop = rd_rx;
   assign rxq.fifo_mode = cur.fifo_en;
   assign rxq.flush = wr_i && (addr_i == uart_status_pkg::OFS_FIFO_CONTROL);

   // ----------------------------------------
   // line status
   // ----------------------------------------
   always_comb begin
      line_status = '0;
      line_status[uart_status_pkg::LS_DATA_READY] = !rxq.empty;
      line_status[uart_status_pkg::LS_OVERRUN] = cur.overrun;
      line_status[uart_status_pkg::LS_PARITY] =
         cur.parity_hold || (!rxq.empty && rxq.head.parity);
      line_status[uart_status_pkg::LS_FRAMING] =
         cur.framing_hold || (!rxq.empty && rxq.head.framing);
      line_status[uart_status_pkg::LS_HOLD_EMPTY] = cur.tx_empty[0];
      line_status[uart_status_pkg::LS_ALL_EMPTY] = cur.tx_empty[1];
   end

   // ----------------------------------------
   // interrupt events
   // ----------------------------------------
   always_comb begin
      irq_set = '0;
      irq_set[uart_status_pkg::IS_OVERRUN] = overrun_set;
      irq_set[uart_status_pkg::IS_PARITY] = accept && cur.shift.parity;
      irq_set[uart_status_pkg::IS_FRAMING] = accept && cur.shift.framing;
      irq_set[uart_status_pkg::IS_MODEM] = |delta_set;
      irq_set[uart_status_pkg::IS_DATA] = accept;
   end

   assign irq_o = |(cur.irq_status & cur.irq_mask);
   assign rdata_o = cur.rdata;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_cur = cur;
      next_cur.primed = 1'b1;
      next_cur.prev = modem_now;
      next_cur.tx_empty = {tx_all_empty_i, tx_hold_empty_i};

      // newest character always lands in the shift register
      next_cur.shift_new = rx_char_valid_i;
      if (rx_char_valid_i) begin
         next_cur.shift.data = rx_char_i;
         next_cur.shift.parity = rx_parity_bad_i;
         next_cur.shift.framing = rx_stop_bad_i;
      end

      // error flags hold until line_status is read, a new event wins
      if (rd_line) begin
         next_cur.overrun = 1'b0;
         next_cur.parity_hold = 1'b0;
         next_cur.framing_hold = 1'b0;
      end
      if (rd_rx && !rxq.empty) begin
         next_cur.parity_hold = cur.parity_hold || rxq.head.parity;
         next_cur.framing_hold = cur.framing_hold || rxq.head.framing;
         if (rd_line) begin
            next_cur.parity_hold = rxq.head.parity;
            next_cur.framing_hold = rxq.head.framing;
         end
      end
      if (overrun_set) begin
         next_cur.overrun = 1'b1;
      end

      // read clears all change bits, a new change wins
      next_cur.delta = (rd_modem ? 4'h0 : cur.delta) | delta_set;

      // sticky interrupt status, write one to clear, set wins
      next_cur.irq_status = cur.irq_status | irq_set;
      if (wr_i && (addr_i == uart_status_pkg::OFS_IRQ_STATUS)) begin
         next_cur.irq_status = (cur.irq_status & ~wdata_i[4:0]) | irq_set;
      end

      if (wr_i) begin
         unique case (addr_i)
            uart_status_pkg::OFS_MODEM_CONTROL: begin
               next_cur.modem_control = wdata_i[4:0];
            end
            uart_status_pkg::OFS_FIFO_CONTROL: begin
               next_cur.fifo_en = wdata_i[uart_status_pkg::FC_ENABLE];
            end
            uart_status_pkg::OFS_IRQ_MASK: begin
               next_cur.irq_mask = wdata_i[4:0];
            end
            default: begin
            end
         endcase
      end

      next_cur.rdata = '0;
      if (rd_i) begin
         unique case (addr_i)
            uart_status_pkg::OFS_RX_DATA: begin
               next_cur.rdata = rxq.empty ? 8'h00 : rxq.head.data;
            end
            uart_status_pkg::OFS_LINE_STATUS: begin
               next_cur.rdata = line_status;
            end
            uart_status_pkg::OFS_MODEM_STATUS: begin
               next_cur.rdata = modem_status;
            end
            uart_status_pkg::OFS_MODEM_CONTROL: begin
               next_cur.rdata = {3'h0, cur.modem_control};
            end
            uart_status_pkg::OFS_FIFO_CONTROL: begin
               next_cur.rdata = {7'h00, cur.fifo_en};
            end
            uart_status_pkg::OFS_IRQ_STATUS: begin
               next_cur.rdata = {3'h0, cur.irq_status};
            end
            uart_status_pkg::OFS_IRQ_MASK: begin
               next_cur.rdata = {3'h0, cur.irq_mask};
            end
            default: begin
               next_cur.rdata = 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         cur <= '0;
         cur.modem_control <= uart_status_pkg::MODEM_CONTROL_RST;
         cur.irq_mask <= uart_status_pkg::IRQ_MASK_RST;
         // transmitter empty bits read one after reset
         cur.tx_empty <= uart_status_pkg::TX_EMPTY_RST;
      end else begin
         cur <= next_cur;
      end
   end
endmodule : uart_line_modem_status

// ===== tb/uart_status_monitor.sv
// concurrent checks on the ports of the status block
`timescale 1ns/1ps
module uart_status_monitor (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic irq_o,
   input wire logic modem_irq_o,
   input wire logic rx_char_valid_i,
   input wire logic cd_n_i,
   input wire logic ri_n_i,
   input wire logic dsr_n_i,
   input wire logic cts_n_i,
   input wire logic dtr_n_o,
   input wire logic rts_n_o,
   input wire logic general_output_one_n_o,
   input wire logic general_output_two_n_o,
   input wire logic loopback_o
);
   // ---------------------------------------------
   // helper logic
   // ---------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   wire logic ms_rd = rd_i && (addr_i == 3'h2);
   wire logic mc_wr = wr_i && (addr_i == 3'h3);
   wire logic [4:0] ctl = {loopback_o, general_output_two_n_o, general_output_one_n_o,
      rts_n_o, dtr_n_o};
   logic [4:0] ctl_exp;
   // control pins forced inactive in loopback
   always_ff @(posedge mclk_i) begin
      ctl_exp <= wdata_i[4] ? 5'h1F : {1'b0, ~wdata_i[3:0]};
   end
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside a read answer");
   chk_unmapped_zero: assert property (rd_i && addr_i == 3'h7 |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   chk_ready_flag: assert property (
      rx_char_valid_i ##1 !(wr_i && addr_i == 3'h4) ##1 (rd_i && addr_i == 3'h1)
      |=> rdata_o[0])
      else $error("data ready missing after a character");
   chk_modem_change: assert property (
      !loopback_o && $changed({cd_n_i, dsr_n_i, cts_n_i}) |-> ##[0:2] modem_irq_o)
      else $error("modem input change raised no request");
   chk_ring_rise: assert property (
      !loopback_o && $rose(ri_n_i) |-> ##[0:2] modem_irq_o)
      else $error("ring pin rise raised no request");
   chk_irq_cleared: assert property (
      $fell(modem_irq_o) |-> $past(ms_rd) || $past(ms_rd, 2))
      else $error("modem request dropped without a status read");
   chk_ctl_write: assert property (mc_wr |=> ctl == ctl_exp)
      else $error("control pins do not follow the control write");
   chk_ctl_hold: assert property (!mc_wr |=> $stable(ctl))
      else $error("control pins moved without a control write");
   chk_loop_quiet: assert property (loopback_o |-> ctl[3:0] == 4'hF)
      else $error("control pins driven in loopback");
   cover property (ms_rd ##1 rdata_o[3:0] != 4'h0);
   cover property (irq_o);
   cover property (loopback_o && ms_rd);
endmodule : uart_status_monitor

bind uart_line_modem_status uart_status_monitor uart_status_monitor_inst (.mclk_i, .rstn_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .modem_irq_o, .rx_char_valid_i,
   .cd_n_i, .ri_n_i, .dsr_n_i, .cts_n_i, .dtr_n_o, .rts_n_o, .general_output_one_n_o,
   .general_output_two_n_o, .loopback_o);

// ===== tb/modem_peer.sv
// modem side model: drives the four active-low modem inputs
`timescale 1ns/1ps
module modem_peer (
   input wire logic mclk_i,
   input wire logic req_i,
   input wire logic [3:0] lvl_i,
   input wire logic [3:0] delay_i,
   output logic [3:0] pins_o
);
   logic [3:0] cnt = 4'h0;
   logic [3:0] hold = 4'hF;
   logic busy = 1'b0;
   // pins rest inactive high and change after the requested delay
   initial pins_o = 4'hF;
   always @(posedge mclk_i) begin
      if (req_i) begin
         hold <= lvl_i;
         cnt <= delay_i;
         busy <= 1'b1;
      end else if (busy && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end else if (busy) begin
         pins_o <= hold;
         busy <= 1'b0;
      end
   end
endmodule : modem_peer

// ===== tb/uart_line_modem_status_tb.sv
// self-checking bench for the uart line and modem status block
`timescale 1ns/1ps
module uart_line_modem_status_tb;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic rx_char_valid_i = 1'b0;
   logic [7:0] rx_char_i = 8'h00;
   logic rx_parity_bad_i = 1'b0;
   logic rx_stop_bad_i = 1'b0;
   logic tx_hold_empty_i = 1'b1;
   logic tx_all_empty_i = 1'b1;
   logic req = 1'b0;
   logic [3:0] lvl = 4'hF;
   logic [3:0] dly = 4'h0;
   logic [3:0] pins;
   logic [7:0] rdata_o;
   logic irq_o, modem_irq_o, dtr_n_o, rts_n_o, general_output_one_n_o;
   logic general_output_two_n_o, loopback_o;
   logic rd_q = 1'b0;
   logic [7:0] expq[$];
   logic [7:0] mskq[$];
   logic [31:0] seed = 32'h0001_117A;
   int n_errors = 0;
   int cmp_count = 0;

   uart_line_modem_status uart_line_modem_status_inst (.mclk_i, .rstn_i, .addr_i, .wdata_i,
      .wr_i, .rd_i, .rdata_o, .irq_o, .modem_irq_o, .rx_char_valid_i, .rx_char_i,
      .rx_parity_bad_i, .rx_stop_bad_i, .tx_hold_empty_i, .tx_all_empty_i,
      .cd_n_i(pins[3]), .ri_n_i(pins[2]), .dsr_n_i(pins[1]), .cts_n_i(pins[0]), .dtr_n_o,
      .rts_n_o, .general_output_one_n_o, .general_output_two_n_o, .loopback_o);
   modem_peer modem_peer_inst (.mclk_i, .req_i(req), .lvl_i(lvl), .delay_i(dly),
      .pins_o(pins));

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   initial forever #5 mclk_i = ~mclk_i;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic cmp8(input logic [7:0] e, input logic [7:0] m, input logic [7:0] g);
      cmp_count++;
      if ((g & m) !== (e & m)) begin
         n_errors++;
         $display("MISMATCH rdata expected %h seen %h", e & m, g & m);
      end
   endtask : cmp8
   task automatic cmp1(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask : cmp1
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      @(posedge mclk_i);
   endtask : wr
   // the read answer is checked by the watcher one cycle later
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
      expq.push_back(e);
      mskq.push_back(m);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(posedge mclk_i);
   endtask : rd
   task automatic rx(input logic [7:0] c, input logic p, input logic s);
      rx_char_valid_i <= 1'b1;
      rx_char_i <= c;
      rx_parity_bad_i <= p;
      rx_stop_bad_i <= s;
      @(posedge mclk_i);
   endtask : rx
   task automatic idle();
      rx_char_valid_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
   endtask : idle
   task automatic modem(input logic [3:0] l);
      logic [31:0] r;
      r = rnd();
      req <= 1'b1;
      lvl <= l;
      dly <= r[3:0];
      @(posedge mclk_i);
      req <= 1'b0;
      repeat (20) @(posedge mclk_i);
   endtask : modem
   task automatic end_sim();
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim
   always @(posedge mclk_i) begin
      if (rd_q) begin
         cmp8(expq.pop_front(), mskq.pop_front(), rdata_o);
      end
      rd_q <= rd_i;
   end
   initial begin
      #100us;
      n_errors++;
      $display("MISMATCH watchdog expected done seen hang");
      end_sim();
   end

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   initial begin
      int i;
      logic [7:0] e;
      logic [31:0] r;
      logic [7:0] fq[16];
      repeat (8) @(posedge mclk_i);
      rstn_i <= 1'b1;
      @(posedge mclk_i);
      rd(3'h1, 8'h60, 8'hFF);
      rd(3'h2, 8'h00, 8'hFF);
      rd(3'h7, 8'h00, 8'hFF);
      for (i = 0; i < 4; i++) begin
         modem(4'hF ^ (4'h1 << i));
         e = {4'h1 << i, (i == 2) ? 4'h0 : 4'h1 << i};
         cmp1("modem_irq", i != 2, modem_irq_o);
         rd(3'h2, e, 8'hFF);
         rd(3'h2, {e[7:4], 4'h0}, 8'hFF);
         cmp1("modem_irq", 1'b0, modem_irq_o);
         modem(4'hF);
         rd(3'h2, {4'h0, 4'h1 << i}, 8'hFF);
      end
      for (i = 0; i < 4; i++) begin
         r = rnd();
         wr(3'h3, {3'h0, 1'b1, r[3:0]});
         rd(3'h2, {r[3], r[2], r[0], r[1], 4'h0}, 8'hF0);
      end
      wr(3'h3, {4'h0, r[3:0]});
      cmp1("dtr_n", ~r[0], dtr_n_o);
      rd(3'h2, {4'h0, r[3], r[2], r[0], r[1]}, 8'hFF);
      rd(3'h2, 8'h00, 8'hFF);
      rd(3'h3, {4'h0, r[3:0]}, 8'hFF);
      r = rnd();
      rx(r[7:0], 1'b1, 1'b0);
      rx_char_valid_i <= 1'b0;
      @(posedge mclk_i);
      rd(3'h1, 8'h01, 8'h01);
      rd(3'h1, 8'h65, 8'hFF);
      rd(3'h0, r[7:0], 8'hFF);
      rd(3'h1, 8'h64, 8'hFF);
      rd(3'h1, 8'h60, 8'hFF);
      rx(r[15:8], 1'b0, 1'b1);
      idle();
      rd(3'h0, r[15:8], 8'hFF);
      rd(3'h1, 8'h68, 8'hFF);
      rd(3'h1, 8'h60, 8'hFF);
      rx(r[23:16], 1'b0, 1'b0);
      idle();
      rx(r[31:24], 1'b0, 1'b0);
      idle();
      rd(3'h1, 8'h63, 8'hFF);
      rd(3'h0, r[23:16], 8'hFF);
      rd(3'h1, 8'h60, 8'hFF);
      wr(3'h4, 8'h01);
      rd(3'h4, 8'h01, 8'hFF);
      for (i = 0; i < 17; i++) begin
         r = rnd();
         if (i < 16) fq[i] = r[7:0];
         rx(r[7:0], 1'b0, i == 1);
      end
      idle();
      rd(3'h1, 8'h63, 8'hFF);
      rd(3'h0, fq[0], 8'hFF);
      rd(3'h1, 8'h69, 8'hFF);
      for (i = 1; i < 16; i++) rd(3'h0, fq[i], 8'hFF);
      rd(3'h1, 8'h68, 8'hFF);
      rd(3'h1, 8'h60, 8'hFF);
      tx_hold_empty_i <= 1'b0;
      @(posedge mclk_i);
      rd(3'h1, 8'h40, 8'hFF);
      tx_hold_empty_i <= 1'b1;
      wr(3'h5, 8'h1F);
      modem(4'hE);
      cmp1("irq", 1'b0, irq_o);
      rd(3'h5, 8'h08, 8'h08);
      rd(3'h2, 8'h11, 8'hFF);
      wr(3'h6, 8'h08);
      rd(3'h6, 8'h08, 8'hFF);
      cmp1("irq", 1'b1, irq_o);
      wr(3'h5, 8'h08);
      cmp1("irq", 1'b0, irq_o);
      repeat (4) @(posedge mclk_i);
      // mid-run reset: status returns to its reset view, inputs still shown
      rstn_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rstn_i <= 1'b1;
      @(posedge mclk_i);
      rd(3'h1, 8'h60, 8'hFF);
      rd(3'h2, 8'h10, 8'hFF);
      cmp1("modem_irq", 1'b0, modem_irq_o);
      repeat (4) @(posedge mclk_i);
      end_sim();
   end
endmodule : uart_line_modem_status_tb
